// ===== include/eeprom_ctl_defs.svh
// Offsets, field positions, reset values and timing counts for the EEPROM
`ifndef EEPROM_CTL_DEFS_SVH
`define EEPROM_CTL_DEFS_SVH

`define CTRL_ADDR      16'h0007
`define ARR_FIRST      16'h0100
`define ARR_LAST       16'h01ff
`define OPT_ADDR       16'h0100
`define PROT_FIRST_OFS 8'h20

`define CTRL_RESET     8'h00
`define BIT_PGM        0
`define BIT_LAT        1
`define BIT_ERA        2
`define BIT_BUS_CLOCK_OUTPUT_SELECT       3
`define BIT_CAF        6
`define BIT_WIRED_OR_IRQ_ENABLE       7
`define OPT_SEC        0
`define OPT_PROT       1
`define PROT_RESET     1'b0
`define SEC_RESET      1'b0

`define ERASED_BYTE    8'hff
`define BLANK_READ     8'hff
`define UNMAPPED_READ  8'h00
`define LAST_OFS       8'hff

`define CLK_PERIOD_NS  40
`define ERASE_TIME_NS  10000
`define PROG_TIME_NS   10000
`define ERASE_CYCLES   ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYCLES    ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== include/eeprom_ctl_pkg.sv
// Types shared by the EEPROM control block
package eeprom_ctl_pkg;

    typedef logic [15:0] addr_t;
    typedef logic [7:0]  byte_t;

    typedef enum logic [2:0]
    {
        ST_READ  = 3'h0,
        ST_ARMED = 3'h1,
        ST_HELD  = 3'h3,
        ST_PUMP  = 3'h2,
        ST_DONE  = 3'h6,
        ST_WIPE  = 3'h4
    } ee_state_e;

endpackage

// ===== core/bit_sync.sv
// Two-flop synchroniser for pin-level inputs
module bit_sync
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Level in and out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else if (clk_en)
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ===== core/eeprom_array.sv
// 256-byte nonvolatile array with byte erase and bit-clearing program
`include "eeprom_ctl_defs.svh"

module eeprom_array
    import eeprom_ctl_pkg::*;
(
    // Clock
    input  wire logic  clk,
    input  wire logic  clk_en,
    // Write port
    input  wire logic  wr_en,
    input  wire logic  erase,
    input  wire byte_t wr_ofs,
    input  wire byte_t wr_data,
    // Read ports
    input  wire byte_t rd_ofs,
    output byte_t      rd_data,
    output byte_t      opt_byte
);

    byte_t mem [256];

    assign rd_data  = mem[rd_ofs];
    assign opt_byte = mem[0];

    // Programming can only pull bits to zero; erase returns them to one
    always_ff @(posedge clk)
    begin
        if (clk_en && wr_en)
        begin
            if (erase)
                mem[wr_ofs] <= `ERASED_BYTE;
            else
                mem[wr_ofs] <= mem[wr_ofs] & wr_data;
        end
    end

endmodule

// ===== core/eeprom_ctl.sv
// EEPROM program/erase control, options latches and control register
//
// Design decision made here: strobed register access.
`include "eeprom_ctl_defs.svh"

module eeprom_ctl
    import eeprom_ctl_pkg::*;
(
    // Clock, reset, enable
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  clk_en,
    // Register port
    input  wire addr_t reg_addr,
    input  wire byte_t reg_wdata,
    input  wire logic  reg_wr,
    input  wire logic  reg_rd,
    output byte_t      reg_rdata,
    // System events, same clock
    input  wire logic  stop_entry,
    input  wire logic  boot_entry,
    // Pin inputs
    input  wire logic  woi_option,
    input  wire logic  net_sleep,
    input  wire logic  test_req,
    // Status and control outputs
    output logic       pump_on,
    output logic       erase_mode,
    output logic       array_busy,
    output logic       woi_enable,
    output logic       bus_clock_output_select_select,
    output logic       test_mode_en,
    output logic       protect_latched,
    output logic       security_latched
);

    localparam logic [15:0] ERASE_CNT = 16'(`ERASE_CYCLES);
    localparam logic [15:0] PROG_CNT  = 16'(`PROG_CYCLES);

    function automatic logic in_array(input addr_t a);
        in_array = (a >= `ARR_FIRST) && (a <= `ARR_LAST);
    endfunction

    function automatic logic is_protected(input byte_t ofs,
                                          input logic  prot);
        is_protected = !prot && (ofs >= `PROT_FIRST_OFS);
    endfunction

    function automatic logic pump_state(input ee_state_e s);
        pump_state = (s == ST_PUMP);
    endfunction

    // States in which the array cannot be accessed
    function automatic logic busy_state(input ee_state_e s);
        busy_state = pump_state(s) || (s == ST_DONE) || (s == ST_WIPE);
    endfunction

    // Synchronised pins
    logic [2:0] pins_s;

    bit_sync #(.W(3)) u_sync
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .d      ({test_req, net_sleep, woi_option}),
        .q      (pins_s)
    );

    wire woi_opt_s  = pins_s[0];
    wire sleep_s    = pins_s[1];
    wire test_req_s = pins_s[2];

    // State
    ee_state_e   st_q;
    ee_state_e   st_d;
    logic        lat_q;
    logic        lat_d;
    logic        era_q;
    logic        era_d;
    logic        pgm_q;
    logic        pgm_d;
    logic        wired_or_irq_enable_q;
    logic        bus_clock_output_select_q;
    logic        caf_q;
    logic        prot_q;
    logic        sec_q;
    logic        opt_load_q;
    byte_t       cap_ofs_q;
    byte_t       cap_data_q;
    logic [15:0] cnt_q;
    byte_t       wipe_q;
    logic        commit;
    byte_t       arr_rd;
    byte_t       opt_byte;

    // Access decoding
    wire ctrl_wr  = reg_wr && (reg_addr == `CTRL_ADDR);
    wire arr_wr   = reg_wr && in_array(reg_addr);
    wire arr_rdh  = in_array(reg_addr);
    wire wr_lat   = reg_wdata[`BIT_LAT];
    wire wr_era   = reg_wdata[`BIT_ERA];
    wire wr_pgm   = reg_wdata[`BIT_PGM];
    wire wiping   = (st_q == ST_WIPE);
    wire wipe_end = wiping && (wipe_q == `LAST_OFS);
    wire [15:0] op_cnt = era_q ? ERASE_CNT : PROG_CNT;
    wire op_due   = pump_state(st_q) && (cnt_q == op_cnt - 16'h0001);
    wire op_fail  = is_protected(cap_ofs_q, prot_q);
    // Erase select freezes once a target is held
    wire era_locked = (st_q != ST_READ) && (st_q != ST_ARMED);
    wire lat_clear  = ctrl_wr && !wr_lat;

    // Test entry needs the security latch loaded and set
    wire test_allow = test_req_s && sec_q && !opt_load_q;

    // Control register image
    wire byte_t ctrl_rd = {wired_or_irq_enable_q, caf_q, 2'b00, bus_clock_output_select_q,
                           era_q, lat_q, pgm_q};

    // Next latch/erase/pump bits and sequence state
    always_comb
    begin
        st_d  = st_q;
        lat_d = lat_q;
        era_d = era_q;
        pgm_d = pgm_q;
        if (wiping)
        begin
            if (wipe_end)
                st_d = ST_READ;
        end
        else if (lat_clear)
        begin
            // Clearing the latch drops erase and pump at once
            lat_d = 1'b0;
            era_d = 1'b0;
            pgm_d = 1'b0;
            st_d  = ST_READ;
        end
        else if (ctrl_wr)
        begin
            lat_d = 1'b1;
            if (!era_locked)
            begin
                era_d = wr_era;
                st_d  = ST_ARMED;
            end
            if (wr_pgm && st_q == ST_HELD)
            begin
                pgm_d = 1'b1;
                st_d  = ST_PUMP;
            end
        end
        else if (arr_wr && st_q == ST_ARMED)
            st_d = ST_HELD;
        else if (op_due)
            st_d = ST_DONE;
        // Stop entry overrides any write in the same cycle
        if (stop_entry && !wiping)
        begin
            lat_d = 1'b0;
            era_d = 1'b0;
            pgm_d = 1'b0;
            st_d  = ST_READ;
        end
        if (boot_entry)
        begin
            lat_d = 1'b0;
            era_d = 1'b0;
            pgm_d = 1'b0;
            st_d  = ST_WIPE;
        end
    end

    // Array write only at the end of a timed operation or during a wipe
    // Clearing the latch early aborts with no partial write; the options
    // byte is rewritten only through this latched path
    assign commit = op_due && !op_fail && !stop_entry && !boot_entry;

    eeprom_array u_array
    (
        .clk      (clk),
        .clk_en   (clk_en),
        .wr_en    (commit || wiping),
        .erase    (era_q || wiping),
        .wr_ofs   (wiping ? wipe_q : cap_ofs_q),
        .wr_data  (cap_data_q),
        .rd_ofs   (reg_addr[7:0]),
        .rd_data  (arr_rd),
        .opt_byte (opt_byte)
    );

    // Read data: latched array reads blank, plain reads see the cells
    wire byte_t arr_view = (lat_q || wiping) ? `BLANK_READ
                                             : arr_rd;
    wire byte_t rd_mux   = (reg_addr == `CTRL_ADDR) ? ctrl_rd
                         : arr_rdh ? arr_view : `UNMAPPED_READ;

    // Sequence state and control bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q  <= ST_READ;
            lat_q <= 1'b0;
            era_q <= 1'b0;
            pgm_q <= 1'b0;
        end
        else if (clk_en)
        begin
            st_q  <= st_d;
            lat_q <= lat_d;
            era_q <= era_d;
            pgm_q <= pgm_d;
        end
    end

    // Captured target and data; the data is used only for programming
    // A protected target is still captured; only the commit is refused
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_ofs_q  <= 8'h00;
            cap_data_q <= 8'h00;
        end
        else if (clk_en && arr_wr && st_q == ST_ARMED && st_d == ST_HELD)
        begin
            cap_ofs_q  <= reg_addr[7:0];
            cap_data_q <= reg_wdata;
        end
    end

    // Pump-on timer and wipe sweep
    // The timer restarts whenever the pump is off
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= 16'h0000;
            wipe_q <= 8'h00;
        end
        else if (clk_en)
        begin
            cnt_q  <= pump_state(st_q) ? cnt_q + 16'h0001 : 16'h0000;
            wipe_q <= wiping ? wipe_q + 8'h01 : 8'h00;
        end
    end

    // Other control register bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wired_or_irq_enable_q <= 1'(`CTRL_RESET >> `BIT_WIRED_OR_IRQ_ENABLE);
            bus_clock_output_select_q <= 1'b0;
            caf_q  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!woi_opt_s)
                wired_or_irq_enable_q <= 1'b0;
            else if (ctrl_wr)
                wired_or_irq_enable_q <= reg_wdata[`BIT_WIRED_OR_IRQ_ENABLE];
            if (ctrl_wr)
                bus_clock_output_select_q <= reg_wdata[`BIT_BUS_CLOCK_OUTPUT_SELECT];
            caf_q <= sleep_s;
        end
    end

    // Options latches load once after each reset and then hold
    // A reprogrammed options byte only shows after the next reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            opt_load_q <= 1'b1;
            prot_q     <= `PROT_RESET;
            sec_q      <= `SEC_RESET;
        end
        else if (clk_en && opt_load_q)
        begin
            opt_load_q <= 1'b0;
            prot_q     <= opt_byte[`OPT_PROT];
            sec_q      <= opt_byte[`OPT_SEC];
        end
    end

    // Registered outputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata        <= `UNMAPPED_READ;
            pump_on          <= 1'b0;
            erase_mode       <= 1'b0;
            array_busy       <= 1'b0;
            woi_enable       <= 1'b0;
            bus_clock_output_select_select      <= 1'b0;
            test_mode_en     <= 1'b0;
            protect_latched  <= `PROT_RESET;
            security_latched <= `SEC_RESET;
        end
        else if (clk_en)
        begin
            reg_rdata        <= reg_rd ? rd_mux : `UNMAPPED_READ;
            pump_on          <= pgm_d;
            erase_mode       <= era_d;
            array_busy       <= busy_state(st_d);
            woi_enable       <= wired_or_irq_enable_q;
            bus_clock_output_select_select      <= bus_clock_output_select_q;
            test_mode_en     <= test_allow;
            protect_latched  <= prot_q;
            security_latched <= sec_q;
        end
    end

endmodule

// ===== bench/eeprom_ctl_sva.sv
// Port-level assertions for the EEPROM control block
module eeprom_ctl_chk
    import eeprom_ctl_pkg::*;
(
    // Clock and reset
    input wire logic  clk,
    input wire logic  rst_n,
    // Register port
    input wire addr_t reg_addr,
    input wire byte_t reg_wdata,
    input wire logic  reg_wr,
    input wire logic  reg_rd,
    input wire byte_t reg_rdata,
    // Events and pins
    input wire logic  stop_entry,
    input wire logic  woi_option,
    // Status outputs
    input wire logic  pump_on,
    input wire logic  erase_mode,
    input wire logic  array_busy,
    input wire logic  woi_enable,
    input wire logic  test_mode_en,
    input wire logic  protect_latched,
    input wire logic  security_latched
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire logic ctl_wr = reg_wr && reg_addr == 16'h0007;
    wire logic arr_rd = reg_rd && reg_addr[15:8] == 8'h01;
    logic [1:0] age_q;

    // Cycles since reset release, saturating
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            age_q <= 2'h0;
        else if (age_q != 2'h3)
            age_q <= age_q + 2'h1;
    end

    latch_clear_a: assert property (ctl_wr && !reg_wdata[1] |=>
        !pump_on && !erase_mode) else $error("pump left on");
    stop_clear_a: assert property (stop_entry |=>
        !pump_on && !erase_mode) else $error("stop kept pump");
    pump_cause_a: assert property ($rose(pump_on) |->
        $past(ctl_wr) && $past(reg_wdata[0])) else $error("pump cause");
    pump_busy_a: assert property (pump_on |-> array_busy)
        else $error("pump without busy");
    ctrl_zero_a: assert property (reg_rd && reg_addr == 16'h0007
        |=> reg_rdata[5:4] == 2'h0) else $error("bits 5:4 set");
    busy_read_a: assert property (arr_rd && (pump_on || erase_mode)
        |=> reg_rdata == 8'hff) else $error("latched read");
    rdata_idle_a: assert property (!$past(reg_rd) |->
        reg_rdata == 8'h00) else $error("read data lingers");
    woi_force_a: assert property (!woi_option [*4] |=>
        !woi_enable) else $error("wired-or enable");
    test_gate_a: assert property (test_mode_en |->
        security_latched) else $error("test mode unlocked");
    opt_hold_a: assert property (age_q == 2'h3 |->
        $stable(protect_latched) && $stable(security_latched))
        else $error("option latch moved");

    cover property ($rose(pump_on));
    cover property (stop_entry);
    cover property ($fell(array_busy));
endmodule

bind eeprom_ctl eeprom_ctl_chk i_chk (.*);

// ===== bench/tb.sv
// Self-checking bench for the EEPROM control block
`include "eeprom_ctl_defs.svh"
module tb
    import eeprom_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic  clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
    logic  stop_entry = 0, boot_entry = 0, woi_option = 0, clk_en = 1;
    logic  net_sleep = 0, test_req = 0, prot = 1;
    logic  pump_on, erase_mode, array_busy, woi_enable;
    logic  bus_clock_output_select_select, test_mode_en, protect_latched, security_latched;
    addr_t reg_addr = 0;
    byte_t reg_wdata = 0, reg_rdata, o, m [256];
    int    fail_count = 0, checked = 0, seed = 32'hb9e84865;

    always #20 clk = ~clk;

    eeprom_ctl i_dut (.*);

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(byte_t got, byte_t exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(addr_t a, byte_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(addr_t a, byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask

    // Full sequence; a second address and, for a program, an erase-bit change are tried
    task automatic op(logic era, byte_t a, byte_t d);
        wr(16'h0007, {5'h0, era, 2'h2});
        wr({8'h01, a}, d);
        wr({8'h01, a + 8'h1}, 8'h00);
        wr(16'h0007, 8'h07);
        rd(16'h0007, {5'h0, era, 2'h3});
        rd({8'h01, a}, 8'hff);
        repeat ((era ? `ERASE_CYCLES : `PROG_CYCLES) + 4) @(posedge clk);
        wr(16'h0007, 8'h00);
        if (prot || a < 8'h20)
            m[a] = era ? 8'hff : m[a] & d;
        rd({8'h01, a}, m[a]);
        rd({8'h01, a + 8'h1}, m[a + 8'h1]);
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        fail_count++;
        finish_test();
    end

    initial
    begin
        do_reset();
        @(posedge clk);
        boot_entry <= 1'b1;
        @(posedge clk);
        boot_entry <= 1'b0;
        #1;
        for (int n = 0; n < 400 && array_busy !== 1'b0; n++)
        begin
            @(posedge clk);
            #1;
        end
        if (array_busy !== 1'b0)
        begin
            fail_count++;
            finish_test();
        end
        foreach (m[i])
            m[i] = 8'hff;
        do_reset();
        chk({6'h0, protect_latched, security_latched}, 8'h03);
        rd(16'h0007, 8'h00);
        rd(16'h0008, 8'h00);
        wr(16'h0007, 8'h02);
        wr(16'h0007, 8'h03);
        rd(16'h0007, 8'h02);
        chk({7'h0, pump_on}, 8'h00);
        repeat (6)
        begin
            o = $random(seed);
            if (o == 8'h00)
                o = 8'h01;
            op($random(seed), o, $random(seed));
        end
        wr(16'h0007, 8'h06);
        wr(16'h0150, 8'h00);
        wr(16'h0007, 8'h07);
        stop_entry <= 1'b1;
        @(posedge clk);
        stop_entry <= 1'b0;
        rd(16'h0007, 8'h00);
        chk({7'h0, pump_on}, 8'h00);
        rd(16'h0150, m[8'h50]);
        woi_option <= 1'b1;
        net_sleep  <= 1'b1;
        test_req   <= 1'b1;
        repeat (4) @(posedge clk);
        wr(16'h0007, 8'h88);
        rd(16'h0007, 8'hc8);
        chk({6'h0, bus_clock_output_select_select, test_mode_en}, 8'h03);
        woi_option <= 1'b0;
        net_sleep  <= 1'b0;
        repeat (4) @(posedge clk);
        rd(16'h0007, 8'h08);
        wr(16'h0007, 8'h00);
        op(1'b0, 8'h00, 8'hfc);
        chk({7'h0, protect_latched}, 8'h01);
        do_reset();
        prot = 1'b0;
        chk({6'h0, protect_latched, security_latched}, 8'h00);
        chk({7'h0, test_mode_en}, 8'h00);
        op(1'b0, 8'h20, 8'h00);
        op(1'b0, 8'h1f, 8'h0f);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(16'h0007, 8'h08);
        clk_en <= 1'b1;
        rd(16'h0007, 8'h00);
        finish_test();
    end
endmodule
